/* hdl/fp_flag_merge.sv */
/*
  merges per-lane flags and decides whether the handler path is entered.
  assumes flags and masks share the same bit layout.
*/
`timescale 1ns/1ps
module fp_flag_merge (
  // lanes
  input  wire fp_resp_pkg::lane_out_s [fp_resp_pkg::LANES-1:0] lanes_i,
  input  wire logic [5:0]                                     mask_i,
  // merged
  output logic [5:0]                                          flags_o,
  output logic                                                trap_o
);
  // bitwise or across lanes; trap when any raised flag is unmasked
  always_comb begin
    flags_o = 6'h00;
    for (int i = 0; i < fp_resp_pkg::LANES; i++) begin
      flags_o = flags_o | lanes_i[i].flags;
    end
    trap_o = (flags_o & ~mask_i) != 6'h00;
  end
endmodule

/* hdl/fp_lane_resp.sv */
/*
  per-lane response: classifies overflow, underflow and inexact and builds result.
  assumes the rounding datapath supplies both unbounded and bounded roundings.
*/
`timescale 1ns/1ps
module fp_lane_resp (
  // control
  input  wire logic                 dbl_i,
  input  wire fp_resp_pkg::rnd_e    rnd_i,
  input  wire logic [5:0]           mask_i,
  // lane
  input  wire fp_resp_pkg::lane_in_s lane_i,
  output fp_resp_pkg::lane_out_s     lane_o
);
  logic signed [15:0] emax;
  logic signed [15:0] emin;
  logic signed [15:0] bias;
  logic signed [15:0] adj;
  logic signed [15:0] e_out;
  logic               ovf;
  logic               unf;
  logic               ovf_m;
  logic               unf_m;
  logic               to_inf;
  logic [63:0]        inf_v;
  logic [63:0]        max_v;
  logic [63:0]        norm_v;

  // pack sign, biased exponent and fraction for the selected format
  function automatic logic [63:0] pack(input logic d, input logic s,
                                       input logic signed [15:0] be,
                                       input logic [52:0] m);
    if (d) begin
      pack = {s, be[10:0], m[51:0]};
    end else begin
      pack = {32'h0, s, be[7:0], m[51:29]};
    end
  endfunction

  // classification and result selection, all combinational
  always_comb begin
    emax   = dbl_i ? fp_resp_pkg::DBL_EMAX : fp_resp_pkg::SGL_EMAX;
    emin   = dbl_i ? fp_resp_pkg::DBL_EMIN : fp_resp_pkg::SGL_EMIN;
    bias   = dbl_i ? fp_resp_pkg::DBL_BIAS : fp_resp_pkg::SGL_BIAS;
    adj    = dbl_i ? fp_resp_pkg::DBL_ADJ  : fp_resp_pkg::SGL_ADJ;
    ovf    = lane_i.valid && !lane_i.zero && (lane_i.exp > emax);
    unf    = lane_i.valid && !lane_i.zero && (lane_i.exp < emin);
    ovf_m  = (mask_i & fp_resp_pkg::EXC_OVERFLOW) != 6'h00;
    unf_m  = (mask_i & fp_resp_pkg::EXC_UNDERFLOW) != 6'h00;
    // infinity for nearest, else only when rounding goes away from zero
    case (rnd_i)
      fp_resp_pkg::RND_NEAREST: to_inf = 1'b1;
      fp_resp_pkg::RND_DOWN:    to_inf = lane_i.sign;
      fp_resp_pkg::RND_UP:      to_inf = !lane_i.sign;
      fp_resp_pkg::RND_ZERO:    to_inf = 1'b0;
      default:                  to_inf = 1'b1;
    endcase
    inf_v  = pack(dbl_i, lane_i.sign, emax + bias + 16'sh0001, 53'h0);
    max_v  = pack(dbl_i, lane_i.sign, emax + bias, {53{1'b1}});     // 1.1..1 * 2^emax
    e_out  = lane_i.exp + bias;
    norm_v = pack(dbl_i, lane_i.sign, e_out, lane_i.mant);
    lane_o.value = norm_v;
    lane_o.flags = 6'h00;
    if (!lane_i.valid) begin
      lane_o.value = 64'h0;
    end else if (lane_i.zero) begin
      lane_o.value = pack(dbl_i, lane_i.sign, 16'sh0000, 53'h0);
      lane_o.flags = lane_i.inexact ? fp_resp_pkg::EXC_PRECISION : 6'h00;
    end else if (ovf && !ovf_m) begin
      // unmasked overflow wins over any inexact response
      lane_o.value = pack(dbl_i, lane_i.sign, e_out - adj, lane_i.mant);
      lane_o.flags = fp_resp_pkg::EXC_OVERFLOW
                   | (lane_i.inexact ? fp_resp_pkg::EXC_PRECISION : 6'h00);
    end else if (ovf) begin
      lane_o.value = to_inf ? inf_v : max_v;
      lane_o.flags = fp_resp_pkg::EXC_OVERFLOW | fp_resp_pkg::EXC_PRECISION;
    end else if (unf && !unf_m) begin
      lane_o.value = pack(dbl_i, lane_i.sign, e_out + adj, lane_i.mant);
      lane_o.flags = fp_resp_pkg::EXC_UNDERFLOW
                   | (lane_i.inexact ? fp_resp_pkg::EXC_PRECISION : 6'h00);
    end else if (unf) begin
      // bounded rounding gives zero, denormal or (after carry) min normal
      lane_o.value = pack(dbl_i, lane_i.sign, lane_i.den_carry ? 16'sh0001 : 16'sh0000,
                          lane_i.den_mant);
      lane_o.flags = lane_i.den_inexact ?
                     (fp_resp_pkg::EXC_UNDERFLOW | fp_resp_pkg::EXC_PRECISION) : 6'h00;
    end else begin
      lane_o.flags = lane_i.inexact ? fp_resp_pkg::EXC_PRECISION : 6'h00;
    end
  end
endmodule

/* hdl/fp_resp_pkg.sv */
/*
  constants and carriers for the post-computation exception response unit.
  assumes ieee-754 single and double encodings and a two-lane packed datapath.
*/
package fp_resp_pkg;
  // exception flag and mask bit masks
  localparam logic [5:0] EXC_PRECISION = 6'h20;
  localparam logic [5:0] EXC_UNDERFLOW = 6'h10;
  localparam logic [5:0] EXC_OVERFLOW  = 6'h08;
  localparam logic [5:0] EXC_DIVZERO   = 6'h04;
  localparam logic [5:0] EXC_DENORMAL  = 6'h02;
  localparam logic [5:0] EXC_INVALID   = 6'h01;
  localparam logic [5:0] MASK_RESET    = 6'h3f;

  // lane count and widths
  localparam int LANES    = 2;
  localparam int EXP_W    = 16;
  localparam int MANT_W   = 53;

  // format geometry
  localparam logic signed [15:0] SGL_EMAX   = 16'sh007f;   // 127
  localparam logic signed [15:0] SGL_EMIN   = -16'sh007e;  // -126
  localparam logic signed [15:0] SGL_BIAS   = 16'sh007f;
  localparam logic signed [15:0] SGL_ADJ    = 16'sh00c0;   // 192
  localparam logic signed [15:0] DBL_EMAX   = 16'sh03ff;   // 1023
  localparam logic signed [15:0] DBL_EMIN   = -16'sh03fe;  // -1022
  localparam logic signed [15:0] DBL_BIAS   = 16'sh03ff;
  localparam logic signed [15:0] DBL_ADJ    = 16'sh0600;   // 1536
  localparam int SGL_FRAC   = 23;
  localparam int DBL_FRAC   = 52;

  // rounding-control codes of the control/status rounding field
  typedef enum logic [1:0] {
    RND_NEAREST = 2'b00,
    RND_DOWN    = 2'b01,
    RND_UP      = 2'b10,
    RND_ZERO    = 2'b11
  } rnd_e;

  // one lane from the rounding datapath: rounded value with unbounded exponent
  typedef struct packed {
    logic                    valid;
    logic                    sign;
    logic                    zero;
    logic signed [EXP_W-1:0] exp;       // unbiased
    logic [MANT_W-1:0]       mant;      // 1.f, msb is the hidden one
    logic                    inexact;   // unbounded rounding was inexact
    logic [MANT_W-1:0]       den_mant;  // bounded-exponent significand when tiny
    logic                    den_carry; // bounded rounding reached min normal
    logic                    den_inexact;
  } lane_in_s;

  typedef struct packed {
    logic [63:0] value;
    logic [5:0]  flags;
  } lane_out_s;
endpackage

/* hdl/simd_fp_ovf_unf_inexact_resp.sv */
/*
  post-computation exception response for packed and scalar fp results.
  assumes the rounding datapath presents one operation per cycle with both
  unbounded and bounded roundings; writeback takes the registered result.
*/
`timescale 1ns/1ps
module simd_fp_ovf_unf_inexact_resp (
  // clock and reset
  input  wire logic                                            mclk_i,
  input  wire logic                                            reset_i,
  // control/status register fields
  input  wire logic [1:0]                                      rnd_ctl_i,
  input  wire logic [5:0]                                      exc_mask_i,
  input  wire logic                                            flag_clear_i,
  // operation from the rounding datapath
  input  wire logic                                            op_valid_i,
  input  wire logic                                            op_dbl_i,
  input  wire fp_resp_pkg::lane_in_s [fp_resp_pkg::LANES-1:0]  lanes_i,
  // writeback and handler path
  output logic                                                 res_valid_o,
  output logic [127:0]                                         res_value_o,
  output logic [5:0]                                           res_flags_o,
  output logic                                                 trap_o,
  output logic [5:0]                                           sticky_flags_o
);
  fp_resp_pkg::lane_out_s [fp_resp_pkg::LANES-1:0] lane_res;
  fp_resp_pkg::rnd_e  rnd;
  logic [5:0]         op_flags;
  logic               op_trap;
  logic               res_valid_d;
  logic               res_valid_q;
  logic [127:0]       res_value_d;
  logic [127:0]       res_value_q;
  logic [5:0]         res_flags_d;
  logic [5:0]         res_flags_q;
  logic               trap_d;
  logic               trap_q;
  logic [5:0]         sticky_d;
  logic [5:0]         sticky_q;

  assign rnd = fp_resp_pkg::rnd_e'(rnd_ctl_i);

  // one response unit per lane, each independent
  for (genvar g = 0; g < fp_resp_pkg::LANES; g++) begin : g_lane
    fp_lane_resp u_lane (
      .dbl_i  (op_dbl_i),
      .rnd_i  (rnd),
      .mask_i (exc_mask_i),
      .lane_i (lanes_i[g]),
      .lane_o (lane_res[g])
    );
  end

  fp_flag_merge u_merge (
    .lanes_i (lane_res),
    .mask_i  (exc_mask_i),
    .flags_o (op_flags),
    .trap_o  (op_trap)
  );

  // result stage; sticky flags keep accumulating, a new event beats a clear
  always_comb begin
    res_valid_d = op_valid_i;
    res_value_d = res_value_q;
    res_flags_d = 6'h00;
    trap_d      = 1'b0;
    sticky_d    = flag_clear_i ? 6'h00 : sticky_q;
    if (op_valid_i) begin
      res_value_d = {lane_res[1].value, lane_res[0].value};
      res_flags_d = op_flags;
      trap_d      = op_trap;
      sticky_d    = sticky_d | op_flags;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      res_valid_q <= 1'b0;
      res_value_q <= 128'h0;
      res_flags_q <= 6'h00;
      trap_q      <= 1'b0;
      sticky_q    <= 6'h00;
    end else begin
      res_valid_q <= res_valid_d;
      res_value_q <= res_value_d;
      res_flags_q <= res_flags_d;
      trap_q      <= trap_d;
      sticky_q    <= sticky_d;
    end
  end

  assign res_valid_o    = res_valid_q;
  assign res_value_o    = res_value_q;
  assign res_flags_o    = res_flags_q;
  assign trap_o         = trap_q;
  assign sticky_flags_o = sticky_q;
endmodule

/* testbench/fp_resp_properties.sv */
/*
  port-level checks of the exception response unit.
  assumes one clock domain and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module fp_resp_properties (
  // clock and reset
  input wire logic         mclk_i,
  input wire logic         reset_i,
  // controls
  input wire logic [5:0]   exc_mask_i,
  input wire logic         flag_clear_i,
  input wire logic         op_valid_i,
  // results
  input wire logic         res_valid_o,
  input wire logic [127:0] res_value_o,
  input wire logic [5:0]   res_flags_o,
  input wire logic         trap_o,
  input wire logic [5:0]   sticky_flags_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  // an op is answered exactly one cycle later
  sequence s_take; op_valid_i ##1 res_valid_o; endsequence
  property p_answer; op_valid_i |-> s_take; endproperty
  property p_idle; !op_valid_i |=> !res_valid_o; endproperty
  // value stands until the next op
  property p_hold; !op_valid_i |=> $stable(res_value_o); endproperty
  property p_trap; res_valid_o |-> trap_o == |(res_flags_o & ~$past(exc_mask_i)); endproperty
  // set beats clear, so new flags always land
  property p_sticky; res_valid_o |-> sticky_flags_o ==
    (res_flags_o | ($past(flag_clear_i) ? 6'h00 : $past(sticky_flags_o))); endproperty
  property p_ovf_p; res_flags_o[3] && $past(exc_mask_i[3]) |-> res_flags_o[5]; endproperty
  property p_unf_p; res_flags_o[4] && $past(exc_mask_i[4]) |-> res_flags_o[5]; endproperty
  property p_quiet; !res_valid_o |-> res_flags_o == 6'h00 && !trap_o; endproperty
  // this unit never raises divide, denormal or invalid
  property p_spare; res_flags_o[2:0] == 3'h0; endproperty
  a_answer: assert property (p_answer) else $error("no result after op");
  a_idle: assert property (p_idle) else $error("result without op");
  a_hold: assert property (p_hold) else $error("value moved without op");
  a_trap: assert property (p_trap) else $error("trap disagrees with mask");
  a_sticky: assert property (p_sticky) else $error("sticky flags wrong");
  a_ovf_p: assert property (p_ovf_p) else $error("masked overflow lacks precision");
  a_unf_p: assert property (p_unf_p) else $error("masked underflow lacks precision");
  a_quiet: assert property (p_quiet) else $error("flags outside a result");
  a_spare: assert property (p_spare) else $error("foreign flag raised");
endmodule
bind simd_fp_ovf_unf_inexact_resp fp_resp_properties u_props (
  .mclk_i(mclk_i), .reset_i(reset_i), .exc_mask_i(exc_mask_i),
  .flag_clear_i(flag_clear_i), .op_valid_i(op_valid_i), .res_valid_o(res_valid_o),
  .res_value_o(res_value_o), .res_flags_o(res_flags_o), .trap_o(trap_o),
  .sticky_flags_o(sticky_flags_o)
);

/* testbench/round_src_model.sv */
/*
  model of the rounding datapath: one lane record per case code.
  assumes codes 0 exact, 1 inexact, 2 huge, 3 tiny exact, 4 tiny inexact, 5 exact zero,
  6 tiny inexact whose bounded rounding carries up to the smallest normal, 7 idle.
*/
`timescale 1ns/1ps
module round_src_model (
  // case selection
  input  wire logic        dbl_i,
  input  wire logic [5:0]  kind_i,
  input  wire logic [1:0]  sign_i,
  input  wire logic [51:0] frac_i,
  // lanes to the response unit
  output fp_resp_pkg::lane_in_s [1:0] lanes_o
);
  // single lanes keep only 23 fraction bits; tiny exact is a bare power of two
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      logic [2:0] k;
      k = kind_i[3*i+:3];
      lanes_o[i] = '0;
      lanes_o[i].valid = k != 3'h7;
      lanes_o[i].sign = sign_i[i];
      lanes_o[i].zero = k == 3'h5;
      lanes_o[i].mant = {1'b1, k == 3'h3 ? 52'h0 : dbl_i ? frac_i : {frac_i[51:29], 29'h0}};
      lanes_o[i].exp = k < 3'h2 ? 16'sh0 : k == 3'h2 ?
        (dbl_i ? fp_resp_pkg::DBL_EMAX : fp_resp_pkg::SGL_EMAX) + 16'sh1 :
        (dbl_i ? fp_resp_pkg::DBL_EMIN : fp_resp_pkg::SGL_EMIN) - 16'sh1;
      lanes_o[i].inexact = k == 3'h1 || k == 3'h2 || k == 3'h4 || k == 3'h6;
      lanes_o[i].den_mant = k == 3'h6 ? {1'b1, 52'h0} : lanes_o[i].mant >> 1;
      lanes_o[i].den_carry = k == 3'h6;
      lanes_o[i].den_inexact = k == 3'h4 || k == 3'h6;
    end
  end
endmodule

/* testbench/test_simd_fp_ovf_unf_inexact_resp.sv */
/*
  random ops through the source model, scoreboard on every result.
  assumes a result one cycle after each op.
*/
`timescale 1ns/1ps
module test_simd_fp_ovf_unf_inexact_resp;
  typedef struct packed {logic [127:0] v; logic [5:0] f; logic t; logic [5:0] s;} note_s;
  logic         mclk_i = 1'b0, reset_i = 1'b1, flag_clear_i = 1'b0;
  logic         op_valid_i = 1'b0, op_dbl_i = 1'b0, res_valid_o, trap_o;
  logic [1:0]   rnd_ctl_i = 2'h0, sgn = 2'h0;
  logic [5:0]   exc_mask_i = 6'h0, kind = 6'h0, res_flags_o, sticky_flags_o, st = 6'h0;
  logic [51:0]  frac = 52'h0;
  logic [127:0] res_value_o;
  logic [31:0]  seed = 32'h25;
  logic [2:0]   kt [8] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7};
  int           n_mismatch = 0, num_checks = 0, cyc = 0;
  note_s        q [$];
  fp_resp_pkg::lane_in_s [1:0] lanes;

  simd_fp_ovf_unf_inexact_resp uut (
    .mclk_i(mclk_i), .reset_i(reset_i), .rnd_ctl_i(rnd_ctl_i), .exc_mask_i(exc_mask_i),
    .flag_clear_i(flag_clear_i), .op_valid_i(op_valid_i), .op_dbl_i(op_dbl_i),
    .lanes_i(lanes), .res_valid_o(res_valid_o), .res_value_o(res_value_o),
    .res_flags_o(res_flags_o), .trap_o(trap_o), .sticky_flags_o(sticky_flags_o));
  round_src_model src (.dbl_i(op_dbl_i), .kind_i(kind), .sign_i(sgn), .frac_i(frac),
    .lanes_o(lanes));

  always #10 mclk_i = ~mclk_i;

  function automatic logic [31:0] rng();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [63:0] pk(logic d, logic s, logic [10:0] be, logic [52:0] m);
    return d ? {s, be, m[51:0]} : {32'h0, s, be[7:0], m[51:29]};
  endfunction

  // expected {value, flags} of one lane under the present controls
  function automatic logic [69:0] ref_lane(logic [2:0] k, logic s, logic [52:0] m);
    logic        d;
    logic        inf;
    logic        c;
    logic [10:0] eb;
    d = op_dbl_i;
    c = k == 3'h6;
    eb = d ? 11'h3ff : 11'h07f;
    inf = rnd_ctl_i == 2'h0 || rnd_ctl_i == {~s, s};
    case (k)
      3'h0: return {pk(d, s, eb, m), 6'h00};
      3'h1: return {pk(d, s, eb, m), 6'h20};
      3'h2: return {exc_mask_i[3] ? pk(d, s, inf ? eb + eb + 11'h1 : eb + eb,
        inf ? 53'h0 : '1) : pk(d, s, d ? 11'h1ff : 11'h03f, m), 6'h28};
      3'h3, 3'h4, 3'h6: return {exc_mask_i[4] ? pk(d, s, {10'h0, c}, c ? 53'h0 : m >> 1) :
        pk(d, s, d ? 11'h600 : 11'h0c0, m), k[2] ? 6'h30 : exc_mask_i[4] ? 6'h00 : 6'h10};
      3'h5: return {pk(d, s, 11'h0, 53'h0), 6'h00};
      default: return '0;
    endcase
  endfunction

  task automatic chk(string nm, logic [127:0] ex, logic [127:0] got);
    num_checks++;
    if (got !== ex) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // driver: random ops, mostly back to back, every mode, mask and lane case
  initial begin
    note_s       e;
    logic [69:0] l;
    logic [31:0] r;
    logic [31:0] r2;
    repeat (12) @(negedge mclk_i);
    reset_i = 1'b0;
    chk("reset flags", 128'h0, {res_valid_o, trap_o, res_flags_o, sticky_flags_o});
    chk("reset value", 128'h0, res_value_o);
    for (int n = 0; n < 3000; n++) begin
      @(negedge mclk_i);
      r = rng();
      op_valid_i = r[0] | r[1];
      op_dbl_i = r[2];
      rnd_ctl_i = r[4:3];
      exc_mask_i = r[10:5];
      flag_clear_i = r[13:11] == 3'h0;
      sgn = r[15:14];
      kind = {kt[r[18:16]], kt[r[21:19]]};
      r2 = rng();
      frac = {rng(), r2[19:0]};
      if (flag_clear_i) st = 6'h0;
      if (op_valid_i) begin
        e = '0;
        for (int i = 0; i < 2; i++) begin
          l = ref_lane(kind[3*i+:3], sgn[i], {1'b1, kind[3*i+:3] == 3'h3 ? 52'h0 : frac});
          e.v[64*i+:64] = l[69:6];
          e.f |= l[5:0];
        end
        e.t = |(e.f & ~exc_mask_i);
        st |= e.f;
        e.s = st;
        q.push_back(e);
      end
    end
    @(negedge mclk_i);
    op_valid_i = 1'b0;
    repeat (3) @(negedge mclk_i);
    chk("pending notes", 128'h0, q.size());
    give_verdict();
  end

  // monitor: oldest note against each result
  always @(negedge mclk_i) begin
    note_s e;
    if (res_valid_o === 1'b1) begin
      e = q.size() > 0 ? q.pop_front() : '1;
      chk("value", e.v, res_value_o);
      chk("flags", e.f, res_flags_o);
      chk("trap", e.t, trap_o);
      chk("sticky", e.s, sticky_flags_o);
    end
  end

  // hang guard
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      give_verdict();
    end
  end
endmodule
